// [hw/acc_channel_config.v]
// Notes on behaviour
// - Bit 15 of the word enables channel zero and comes out of reset set.
// - With several channels enabled the sequencer converts each in turn on its own.
// - Bits 13:12 pick setup zero to three and reset to setup zero.
// - The picked setup brings its four registers (setup, filter, offset, gain) to the channel.
// - Bits 9:5 pick the positive input from the legal code set and reset to zero.
// - The word is 16 bits at offset 0x10 and reads 0x8001 after reset.
// - Bits 4:0 pick the negative input from the same code set and reset to 00001.
`timescale 1ns/100ps
`include "acc_consts.vh"

module acc_channel_config #(
  parameter ADDR_W = 8,
  parameter NUM_CH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire convDone,
  output wire convStart,
  output wire [1:0] convChannel,
  output reg [1:0] convSetup,
  output reg [4:0] convPositiveInput,
  output reg [4:0] convNegativeInput,
  output reg [3:0] setupBankSelect,
  output wire scanBusy,
  output wire channelEnable,
  output wire [1:0] setupSelect,
  output wire [4:0] positiveInputSelect,
  output wire [4:0] negativeInputSelect
);

  // ****************************************
  // helpers
  // ****************************************
  // byte-lane merge, used only by the channel configuration register
  function [15:0] laneMerge;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0] strb;
    begin
      laneMerge[7:0] = strb[0] ? newVal[7:0] : oldVal[7:0];
      laneMerge[15:8] = strb[1] ? newVal[15:8] : oldVal[15:8];
    end
  endfunction

  // codes the input multiplexer actually decodes
  function codeLegal;
    input [4:0] code;
    begin
      codeLegal = (code <= 5'h04) || ((code >= 5'h11) && (code <= 5'h16));
    end
  endfunction

  // one-hot bank pick for the setup register group
  function [3:0] bankDecode;
    input [1:0] sel;
    begin
      bankDecode = 4'h1 << sel;
    end
  endfunction

  // word-aligned address; the low two bits never matter
  function [ADDR_W-1:0] wordAddr;
    input [ADDR_W-1:0] addr;
    begin
      wordAddr = {addr[ADDR_W-1:2], 2'h0};
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  reg [15:0] chanCfg_q;
  reg [3:0] ctrl_q;
  reg [7:0] convCount_q;
  reg appliedChanZero_q;
  reg [ADDR_W-1:0] awAddr_q;
  reg awHeld_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg wHeld_q;

  wire [3:0] channelMask;
  wire runEnable;
  wire launch;
  wire [1:0] nextChannel;
  wire doWrite;
  wire [15:0] statusWord;
  reg [31:0] readWord;
  reg readHit;

  // ****************************************
  // live fields
  // ****************************************
  assign channelEnable = chanCfg_q[`ACC_EN_BIT];
  assign setupSelect = chanCfg_q[`ACC_SETUP_HI:`ACC_SETUP_LO];
  assign positiveInputSelect = chanCfg_q[`ACC_POS_HI:`ACC_POS_LO];
  assign negativeInputSelect = chanCfg_q[`ACC_NEG_HI:`ACC_NEG_LO];
  assign runEnable = ctrl_q[`ACC_CTRL_RUN_BIT];
  // channel zero enable joins the enables of the other three channels
  assign channelMask = {ctrl_q[3:1], channelEnable};

  // ****************************************
  // scan sequencer
  // ****************************************
  acc_scan_sequencer #(
    .NUM_CH(NUM_CH)
  ) u_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .runEnable(runEnable),
    .channelMask(channelMask),
    .convDone(convDone),
    .launch(launch),
    .nextChannel(nextChannel),
    .convStart_q(convStart),
    .currentChannel_q(convChannel),
    .busy(scanBusy)
  );

  // ****************************************
  // applied configuration
  // ****************************************
  // snapshot at launch so a write during a conversion waits for the next one
  always @(posedge ref_clk) begin
    if (rst) begin
      convSetup <= 2'h0;
      convPositiveInput <= 5'h00;
      convNegativeInput <= 5'h00;
      setupBankSelect <= 4'h0;
      appliedChanZero_q <= 1'b0;
    end else if (launch) begin
      if (nextChannel == 2'h0) begin
        convSetup <= setupSelect;
        convPositiveInput <= positiveInputSelect;
        convNegativeInput <= negativeInputSelect;
        setupBankSelect <= bankDecode(setupSelect);
        appliedChanZero_q <= 1'b1;
      end else begin
        // other channels' words live elsewhere; bank zero is a safe default
        convSetup <= 2'h0;
        convPositiveInput <= 5'h00;
        convNegativeInput <= 5'h00;
        setupBankSelect <= bankDecode(2'h0);
        appliedChanZero_q <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      convCount_q <= 8'h00;
    end else if (convDone && scanBusy && (convChannel == 2'h0)) begin
      convCount_q <= convCount_q + 8'h01;
    end
  end

  // illegal codes are stored as written and only flagged here
  assign statusWord = {convCount_q,
                       2'h0,
                       appliedChanZero_q,
                       !codeLegal(negativeInputSelect),
                       !codeLegal(positiveInputSelect),
                       scanBusy,
                       convChannel};

  // ****************************************
  // write channels
  // ****************************************
  // address and data are taken in either order; one write in flight
  // readies drop while a response waits, so no write overtakes its answer
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always @(posedge ref_clk) begin
    if (rst) begin
      awAddr_q <= {ADDR_W{1'b0}};
      awHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      wHeld_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // register writes and write response
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      chanCfg_q <= `ACC_CHCFG_RESET;
      ctrl_q <= `ACC_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACC_RESP_OKAY;
    end else begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ACC_RESP_OKAY;
        case (wordAddr(awAddr_q))
          `ACC_CHCFG_OFFSET: begin
            // reserved bits stay zero whatever is written
            chanCfg_q <= laneMerge(chanCfg_q, wData_q[15:0], wStrb_q[1:0]) &
                         `ACC_CHCFG_WMASK;
          end
          `ACC_CTRL_OFFSET: begin
            // only lane zero holds control bits
            if (wStrb_q[0]) begin
              ctrl_q <= wData_q[3:0];
            end
          end
          `ACC_STATUS_OFFSET: begin
            // read-only: write ignored, still answered OKAY
          end
          default: begin
            s_axi_bresp <= `ACC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // read decode
  // ****************************************
  always @* begin
    readWord = 32'h00000000;
    readHit = 1'b1;
    case (wordAddr(s_axi_araddr))
      `ACC_CHCFG_OFFSET: begin
        readWord = {16'h0000, chanCfg_q};
      end
      `ACC_STATUS_OFFSET: begin
        readWord = {16'h0000, statusWord};
      end
      `ACC_CTRL_OFFSET: begin
        readWord = {28'h0000000, ctrl_q};
      end
      default: begin
        readHit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // read channel
  // ****************************************
  // one read in flight; data latched at the take so it stands until rready
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= readHit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // acc_channel_config

// [hw/acc_consts.vh]
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// ****************************************
// register byte addresses
// ****************************************
`define ACC_CHCFG_OFFSET 8'h10
`define ACC_STATUS_OFFSET 8'h14
`define ACC_CTRL_OFFSET 8'h18

// ****************************************
// channel configuration word
// ****************************************
`define ACC_CHCFG_RESET 16'h8001
`define ACC_CHCFG_WMASK 16'hB3FF
`define ACC_EN_BIT 15
`define ACC_SETUP_HI 13
`define ACC_SETUP_LO 12
`define ACC_POS_HI 9
`define ACC_POS_LO 5
`define ACC_NEG_HI 4
`define ACC_NEG_LO 0

// ****************************************
// control word and bus answers
// ****************************************
`define ACC_CTRL_RESET 4'h0
`define ACC_CTRL_RUN_BIT 0
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// [hw/acc_scan_sequencer.v]
`timescale 1ns/100ps
`include "acc_consts.vh"

module acc_scan_sequencer #(
  parameter NUM_CH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire runEnable,
  input wire [3:0] channelMask,
  input wire convDone,
  output wire launch,
  output wire [1:0] nextChannel,
  output reg convStart_q,
  output reg [1:0] currentChannel_q,
  output wire busy
);

  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_RUN = 1'b1;

  reg state_q;

  // ****************************************
  // round-robin pick
  // ****************************************
  // searches from the channel after cur, so the running one comes last
  function [1:0] pickNext;
    input [3:0] mask;
    input [1:0] cur;
    integer i;
    reg found;
    reg [1:0] cand;
    begin
      found = 1'b0;
      pickNext = cur;
      for (i = 1; i <= NUM_CH; i = i + 1) begin
        cand = cur + i[1:0];
        if (!found && mask[cand]) begin
          pickNext = cand;
          found = 1'b1;
        end
      end
    end
  endfunction

  assign busy = (state_q == ST_RUN);
  // a new conversion starts when idle or as the previous one ends
  assign launch = runEnable && (channelMask != 4'h0) &&
                  ((state_q == ST_IDLE) || convDone);
  assign nextChannel = pickNext(channelMask,
                                busy ? currentChannel_q : 2'h3);

  // ****************************************
  // state machine
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      convStart_q <= 1'b0;
      currentChannel_q <= 2'h0;
    end else begin
      convStart_q <= launch;
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            currentChannel_q <= nextChannel;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (launch) begin
            currentChannel_q <= nextChannel;
          end else if (convDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // acc_scan_sequencer

// [tb/acc_channel_config_asserts.sv]
`timescale 1ns/100ps
module acc_channel_config_asserts #(
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire convStart,
  input wire [1:0] convChannel,
  input wire [1:0] convSetup,
  input wire [4:0] convPositiveInput,
  input wire [4:0] convNegativeInput,
  input wire [3:0] setupBankSelect,
  input wire scanBusy,
  input wire channelEnable,
  input wire [1:0] setupSelect,
  input wire [4:0] positiveInputSelect,
  input wire [4:0] negativeInputSelect
);
  reg rdChanCfg_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      rdChanCfg_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdChanCfg_q <= (s_axi_araddr[7:2] == 6'h04);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_word: assert property ($past(rst) |-> channelEnable && setupSelect == 2'h0
    && positiveInputSelect == 5'h00 && negativeInputSelect == 5'h01) else $error("bad reset word");
  a_reserved_zero: assert property (s_axi_rvalid && rdChanCfg_q |->
    s_axi_rdata[14] == 1'b0 && s_axi_rdata[11:10] == 2'h0) else $error("reserved bit set");
  a_start_pulse: assert property (convStart |=> !convStart) else $error("long start");
  a_start_busy: assert property (convStart |-> scanBusy) else $error("start not busy");
  a_busy_cause: assert property ($rose(scanBusy) |-> convStart) else $error("busy no start");
  a_snap_fields: assert property (convStart && convChannel == 2'h0 |->
    convSetup == $past(setupSelect) && convPositiveInput == $past(positiveInputSelect)
    && convNegativeInput == $past(negativeInputSelect)) else $error("snapshot wrong");
  a_bank_pick: assert property (convStart && convChannel == 2'h0 |->
    setupBankSelect == (4'h1 << convSetup)) else $error("bank wrong");
  a_fields_hold: assert property (!$stable({convSetup, convPositiveInput, convNegativeInput})
    |-> convStart) else $error("fields moved");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  cover property (convStart && convChannel == 2'h1);
  cover property (convStart && convChannel == 2'h0);
  cover property (s_axi_rvalid && rdChanCfg_q);
endmodule // acc_channel_config_asserts
bind acc_channel_config acc_channel_config_asserts #(.ADDR_W(ADDR_W)) chk (.ref_clk, .rst,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .convStart, .convChannel,
  .convSetup, .convPositiveInput, .convNegativeInput, .setupBankSelect, .scanBusy,
  .channelEnable, .setupSelect, .positiveInputSelect, .negativeInputSelect);

// [tb/acc_channel_config_bench.sv]
`timescale 1ns/100ps
`include "acc_consts.vh"
module acc_channel_config_bench;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, convDone = 1'b0;
  reg s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire convStart, scanBusy, channelEnable;
  wire [1:0] s_axi_bresp, s_axi_rresp, convChannel, convSetup, setupSelect;
  wire [31:0] s_axi_rdata;
  wire [4:0] convPositiveInput, convNegativeInput, positiveInputSelect, negativeInputSelect;
  wire [3:0] setupBankSelect;
  integer errCount = 0, numChecks = 0;
  reg [31:0] rd;
  reg [1:0] rsp;
  localparam [39:0] CODES = {5'h16, 5'h15, 5'h12, 5'h11, 5'h04, 5'h03, 5'h01, 5'h00};
  always #12.5 ref_clk = ~ref_clk;
  acc_channel_config DUT (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .convDone, .convStart, .convChannel, .convSetup,
    .convPositiveInput, .convNegativeInput, .setupBankSelect, .scanBusy, .channelEnable,
    .setupSelect, .positiveInputSelect, .negativeInputSelect);
  // ****************
  // bus and compare
  // ****************
  task chk(input [31:0] got, input [31:0] exp);
    numChecks = numChecks + 1;
    if (got !== exp) begin
      errCount = errCount + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ready stays low after each take, so no flags are needed
  task axiWrite(input [7:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask
  task axiRead(input [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task waitStart;
    integer n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (convStart !== 1'b1 && n < 40);
    chk(convStart, 1);
  endtask
  task pulseDone;
    convDone <= 1'b1;
    @(posedge ref_clk);
    convDone <= 1'b0;
    waitStart;
  endtask
  // ****************
  // scenarios
  // ****************
  task testReset;
    axiRead(`ACC_CHCFG_OFFSET);
    chk(rd[15:0], 16'h8001);
    chk({channelEnable, setupSelect}, 3'h4);
    chk({positiveInputSelect, negativeInputSelect}, 10'h001);
    axiRead(8'h40);
    chk(rsp, 2'h2);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask
  task testFields;
    integer k;
    reg [15:0] w;
    axiWrite(`ACC_CHCFG_OFFSET, 32'h0000FFFF);
    axiRead(`ACC_CHCFG_OFFSET);
    chk(rd[15:0], 16'hB3FF);
    for (k = 0; k < 8; k = k + 1) begin
      w = {1'b1, 1'b0, k[1:0], 2'h0, CODES[k*5+:5], CODES[(7-k)*5+:5]};
      axiWrite(`ACC_CHCFG_OFFSET, {16'h0, w});
      axiRead(`ACC_CHCFG_OFFSET);
      chk(rd[15:0], w);
      chk({setupSelect, positiveInputSelect, negativeInputSelect}, {w[13:12], w[9:0]});
    end
    axiWrite(8'h40, 32'h0);
    chk(rsp, 2'h2);
    $display("field test done");
  endtask
  task testScan;
    axiWrite(`ACC_CHCFG_OFFSET, 32'h0000A236);
    axiWrite(`ACC_CTRL_OFFSET, 32'h3);
    waitStart;
    chk({convChannel, convSetup, convPositiveInput, convNegativeInput}, 14'h0A36);
    chk(setupBankSelect, 4'h4);
    axiWrite(`ACC_CHCFG_OFFSET, 32'h00000236);
    chk(convSetup, 2'h2);
    pulseDone;
    chk({convChannel, setupBankSelect}, 6'h11);
    pulseDone;
    chk(convChannel, 2'h1);
    // channels 1 to 3 run setup zero, so a shared setup means zero here
    axiWrite(`ACC_CHCFG_OFFSET, 32'h00008236);
    pulseDone;
    chk({convChannel, convSetup, setupBankSelect}, 8'h01);
    axiWrite(`ACC_CTRL_OFFSET, 32'h0);
    convDone <= 1'b1;
    @(posedge ref_clk);
    convDone <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(scanBusy, 1'b0);
    axiRead(`ACC_STATUS_OFFSET);
    chk(rd, 32'h00000220);
    $display("scan test done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    errCount = errCount + 1;
    conclude;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    testReset;
    testFields;
    testScan;
    conclude;
  end
endmodule // acc_channel_config_bench
